// ==== src/uidp_link_if.sv ====
// Interface joining the requesting master and the subordinate
`timescale 1ns/1ns
`default_nettype none
interface uidp_link_if #(parameter int ID_W = 4);
   // Read address channel
   logic ar_valid;
   logic ar_ready;
   logic [ID_W-1:0] ar_id;
   logic ar_idunq;
   logic ar_dvm;
   logic [2:0] ar_prot;
   logic [10:0] ar_part;
   // Read data channel
   logic r_valid;
   logic r_ready;
   logic [ID_W-1:0] r_id;
   logic r_idunq;
   logic r_last;
   // Write address channel
   logic aw_valid;
   logic aw_ready;
   logic [ID_W-1:0] aw_id;
   logic aw_idunq;
   logic [2:0] aw_prot;
   logic [10:0] aw_part;
   // Write response channel
   logic b_valid;
   logic b_ready;
   logic [ID_W-1:0] b_id;
   logic b_idunq;
   logic b_comp;

   modport mst (
      output ar_valid, ar_id, ar_idunq, ar_dvm, ar_prot, ar_part, r_ready,
      output aw_valid, aw_id, aw_idunq, aw_prot, aw_part, b_ready,
      input ar_ready, r_valid, r_id, r_idunq, r_last,
      input aw_ready, b_valid, b_id, b_idunq, b_comp
   );
   modport sub (
      input ar_valid, ar_id, ar_idunq, ar_dvm, ar_prot, ar_part, r_ready,
      input aw_valid, aw_id, aw_idunq, aw_prot, aw_part, b_ready,
      output ar_ready, r_valid, r_id, r_idunq, r_last,
      output aw_ready, b_valid, b_id, b_idunq, b_comp
   );
endinterface
`default_nettype wire

// ==== src/uidp_mst.sv ====
// Master end: tracks outstanding IDs, sets unique flags, packs partition
`timescale 1ns/1ns
`default_nettype none
module uidp_mst #(
   parameter int ID_W = 4,
   parameter bit UNIQUE_ID_SUPPORT = 1'b1,
   parameter bit PART_SUPPORT = 1'b1,
   parameter bit USE_UNQ = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link
   uidp_link_if.mst lnk,
   // User read request
   input wire logic rd_req,
   input wire logic [ID_W-1:0] rd_id,
   input wire logic rd_dvm,
   input wire logic [2:0] rd_prot,
   // User write request
   input wire logic wr_req,
   input wire logic [ID_W-1:0] wr_id,
   input wire logic [2:0] wr_prot,
   // User partition fields
   input wire logic part_own,
   input wire logic part_ns,
   input wire logic [8:0] part_id,
   input wire logic part_mg,
   // Status
   output logic rd_busy_r,
   output logic wr_busy_r,
   output logic rd_done_r,
   output logic wr_done_r
);
   localparam int NID = 1 << ID_W;
   logic [uidp_pkg::CNT_W-1:0] rcnt_r [NID];
   logic [uidp_pkg::CNT_W-1:0] wcnt_r [NID];
   logic [NID-1:0] runq_r;
   logic [NID-1:0] wunq_r;
   logic ar_valid_r;
   logic aw_valid_r;
   logic [ID_W-1:0] ar_id_r;
   logic [ID_W-1:0] aw_id_r;
   logic ar_unq_r;
   logic aw_unq_r;
   logic ar_dvm_r;
   logic [2:0] ar_prot_r;
   logic [2:0] aw_prot_r;
   logic [10:0] ar_part_r;
   logic [10:0] aw_part_r;
   logic rd_ok;
   logic wr_ok;
   logic r_end;
   logic b_end;

   // Issue blocked while a unique request of that ID is outstanding
   assign rd_ok = !runq_r[rd_id];
   assign wr_ok = !wunq_r[wr_id];
   assign r_end = lnk.r_valid && lnk.r_ready && lnk.r_last;
   assign b_end = lnk.b_valid && lnk.b_ready && lnk.b_comp;

   // Partition packing, defaults taken without own signalling
   function automatic logic [10:0] pack(input logic [2:0] prot);
      logic [10:0] v;
      v = '0;
      if (part_own) begin
         v[uidp_pkg::PART_NS_POS] = part_ns;
         v[uidp_pkg::PART_ID_MSB:uidp_pkg::PART_ID_LSB] = part_id;
         v[uidp_pkg::PART_MG_POS] = part_mg;
      end else begin
         v[uidp_pkg::PART_NS_POS] = prot[uidp_pkg::PROT_NS_POS];
         v[uidp_pkg::PART_ID_MSB:uidp_pkg::PART_ID_LSB] =
            uidp_pkg::PART_ID_RST;
         v[uidp_pkg::PART_MG_POS] = uidp_pkg::PART_MG_RST;
      end
      return v;
   endfunction

   // Address channels held until accepted
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ar_valid_r <= 1'b0;
         ar_id_r <= '0;
         ar_unq_r <= 1'b0;
         ar_dvm_r <= 1'b0;
         ar_prot_r <= '0;
         ar_part_r <= '0;
         aw_valid_r <= 1'b0;
         aw_id_r <= '0;
         aw_unq_r <= 1'b0;
         aw_prot_r <= '0;
         aw_part_r <= '0;
      end else begin
         if (ar_valid_r && lnk.ar_ready)
            ar_valid_r <= 1'b0;
         else if (!ar_valid_r && rd_req && rd_ok) begin
            ar_valid_r <= 1'b1;
            ar_id_r <= rd_id;
            // Optional flag, only with no same-ID read
            ar_unq_r <= UNIQUE_ID_SUPPORT && USE_UNQ &&
                        rcnt_r[rd_id] == uidp_pkg::CNT_RST;
            ar_dvm_r <= rd_dvm;
            ar_prot_r <= rd_prot;
            ar_part_r <= PART_SUPPORT ? pack(rd_prot) : '0;
         end
         if (aw_valid_r && lnk.aw_ready)
            aw_valid_r <= 1'b0;
         else if (!aw_valid_r && wr_req && wr_ok) begin
            aw_valid_r <= 1'b1;
            aw_id_r <= wr_id;
            aw_unq_r <= UNIQUE_ID_SUPPORT && USE_UNQ &&
                        wcnt_r[wr_id] == uidp_pkg::CNT_RST;
            aw_prot_r <= wr_prot;
            aw_part_r <= PART_SUPPORT ? pack(wr_prot) : '0;
         end
      end
   end

   // Outstanding counts from valid to final accepted response
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NID; i++) begin
            rcnt_r[i] <= uidp_pkg::CNT_RST;
            wcnt_r[i] <= uidp_pkg::CNT_RST;
         end
         runq_r <= '0;
         wunq_r <= '0;
      end else begin
         for (int i = 0; i < NID; i++) begin
            // Issue and end of one ID in one cycle cancel out
            rcnt_r[i] <= rcnt_r[i] +
               8'(!ar_valid_r && rd_req && rd_ok && rd_id == ID_W'(i)) -
               8'(r_end && lnk.r_id == ID_W'(i));
            if (!ar_valid_r && rd_req && rd_ok && rd_id == ID_W'(i))
               runq_r[i] <= UNIQUE_ID_SUPPORT && USE_UNQ &&
                            rcnt_r[i] == uidp_pkg::CNT_RST;
            else if (r_end && lnk.r_id == ID_W'(i))
               runq_r[i] <= 1'b0;
            wcnt_r[i] <= wcnt_r[i] +
               8'(!aw_valid_r && wr_req && wr_ok && wr_id == ID_W'(i)) -
               8'(b_end && lnk.b_id == ID_W'(i));
            if (!aw_valid_r && wr_req && wr_ok && wr_id == ID_W'(i))
               wunq_r[i] <= UNIQUE_ID_SUPPORT && USE_UNQ &&
                            wcnt_r[i] == uidp_pkg::CNT_RST;
            else if (b_end && lnk.b_id == ID_W'(i))
               wunq_r[i] <= 1'b0;
         end
      end
   end

   // Status toward user
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_busy_r <= 1'b0;
         wr_busy_r <= 1'b0;
         rd_done_r <= 1'b0;
         wr_done_r <= 1'b0;
      end else begin
         rd_busy_r <= ar_valid_r;
         wr_busy_r <= aw_valid_r;
         rd_done_r <= r_end;
         wr_done_r <= b_end;
      end
   end

   // Link outputs; always ready for responses, so interleave is fine
   assign lnk.ar_valid = ar_valid_r;
   assign lnk.ar_id = ar_id_r;
   assign lnk.ar_idunq = ar_unq_r;
   assign lnk.ar_dvm = ar_dvm_r;
   assign lnk.ar_prot = ar_prot_r;
   assign lnk.ar_part = ar_part_r;
   assign lnk.aw_valid = aw_valid_r;
   assign lnk.aw_id = aw_id_r;
   assign lnk.aw_idunq = aw_unq_r;
   assign lnk.aw_prot = aw_prot_r;
   assign lnk.aw_part = aw_part_r;
   assign lnk.r_ready = 1'b1;
   assign lnk.b_ready = 1'b1;
endmodule
`default_nettype wire

// ==== src/uidp_pkg.sv ====
// Shared constants and types for the unique-ID and partition sideband block
package uidp_pkg;
   // ----------------------------------------------------------------
   // Partition information layout
   // ----------------------------------------------------------------
   localparam int PART_W = 11;
   localparam int PART_NS_POS = 0;
   localparam int PART_ID_LSB = 1;
   localparam int PART_ID_MSB = 9;
   localparam int PART_MG_POS = 10;
   localparam logic [8:0] PART_ID_RST = 9'h000;
   localparam logic PART_MG_RST = 1'h0;
   localparam int PROT_NS_POS = 1;
   // ----------------------------------------------------------------
   // Counter reset value and width
   // ----------------------------------------------------------------
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam int CNT_W = 8;
   // Subordinate response sequencer states
   typedef enum logic [2:0] {
      UIDP_IDLE = 3'b001,
      UIDP_RDAT = 3'b010,
      UIDP_WRSP = 3'b100
   } uidp_state_t;
endpackage

// ==== src/uidp_sub.sv ====
// Subordinate end: records unique flags, echoes them, samples partition
// How it works
// - Master may forbid interleaved read data
// - Interleave off: one read ID at a time
// - Undeclared interleave property means false
// - Multi-ID masters must accept interleaving
// - Unique flags present only when supported
// - Read unique flag only with no same-ID read
// - No read reuse of outstanding unique ID
// - Read request flag low gives data flag low
// - Read request flag high gives data flag high
// - Write unique flag only with no same-ID write
// - No write reuse of outstanding unique ID
// - Write response flag echoes request flag
// - Outstanding from address valid to last response
// - With completion flag, wait for completion response
// - Atomic needs both read and write responses
// - Unique flag is optional for master
// - Eleven-bit partition bus when enabled
// - Security bit0, identifier 9:1, group bit10
// - Missing partition signalling gets defaults
// - Master drives partition info with address valid
// - Differing security needs own partition signals
// - Sample partition on valid; ignore DVM reads; a read accepted in the same cycle as a write is not sampled
`timescale 1ns/1ns
`default_nettype none
module uidp_sub #(
   parameter int ID_W = 4,
   parameter int DEPTH = 4,
   parameter int RBEATS = 2,
   parameter bit UNIQUE_ID_SUPPORT = 1'b1,
   parameter bit PART_SUPPORT = 1'b1,
   parameter bit RD_INTERLEAVE_DIS = 1'b0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link
   uidp_link_if.sub lnk,
   // Sampled partition info for the memory side
   output logic part_vld_r,
   output logic [8:0] part_id_r,
   output logic part_mg_r,
   output logic part_ns_r,
   output logic part_wr_r
);
   // ----------------------------------------------------------------
   // Request queues: id and unique flag held together
   // ----------------------------------------------------------------
   localparam int PW = $clog2(DEPTH);
   logic [ID_W-1:0] rq_id [DEPTH];
   logic rq_unq [DEPTH];
   logic [ID_W-1:0] wq_id [DEPTH];
   logic wq_unq [DEPTH];
   logic [PW:0] rq_wp_r;
   logic [PW:0] rq_rp_r;
   logic [PW:0] wq_wp_r;
   logic [PW:0] wq_rp_r;
   logic rq_full;
   logic wq_full;
   logic rq_empty;
   logic wq_empty;
   logic ar_hs;
   logic aw_hs;
   logic r_hs;
   logic b_hs;
   logic ar_ready_r;
   logic aw_ready_r;
   logic r_valid_r;
   logic b_valid_r;
   logic [ID_W-1:0] r_id_r;
   logic r_idunq_r;
   logic r_last_r;
   logic [ID_W-1:0] b_id_r;
   logic b_idunq_r;
   logic [7:0] beat_r;
   uidp_pkg::uidp_state_t state_r;

   assign rq_full = (rq_wp_r[PW] != rq_rp_r[PW]) &&
                    (rq_wp_r[PW-1:0] == rq_rp_r[PW-1:0]);
   assign wq_full = (wq_wp_r[PW] != wq_rp_r[PW]) &&
                    (wq_wp_r[PW-1:0] == wq_rp_r[PW-1:0]);
   assign rq_empty = rq_wp_r == rq_rp_r;
   assign wq_empty = wq_wp_r == wq_rp_r;
   assign ar_hs = lnk.ar_valid && ar_ready_r;
   assign aw_hs = lnk.aw_valid && aw_ready_r;
   assign r_hs = r_valid_r && lnk.r_ready;
   assign b_hs = b_valid_r && lnk.b_ready;

   // Ready while queue has room; a read entry frees on its last beat only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ar_ready_r <= 1'b0;
         aw_ready_r <= 1'b0;
      end else begin
         ar_ready_r <= !rq_full && !(ar_hs && rq_wp_r[PW-1:0] + 1'b1 ==
                        rq_rp_r[PW-1:0] && !(r_hs && r_last_r));
         aw_ready_r <= !wq_full && !(aw_hs && wq_wp_r[PW-1:0] + 1'b1 ==
                        wq_rp_r[PW-1:0] && !b_hs);
      end
   end

   // Store accepted read and write requests with their flag
   always_ff @(posedge mclk) begin
      if (ar_hs) begin
         rq_id[rq_wp_r[PW-1:0]] <= lnk.ar_id;
         rq_unq[rq_wp_r[PW-1:0]] <= UNIQUE_ID_SUPPORT && lnk.ar_idunq;
      end
      if (aw_hs) begin
         wq_id[wq_wp_r[PW-1:0]] <= lnk.aw_id;
         wq_unq[wq_wp_r[PW-1:0]] <= UNIQUE_ID_SUPPORT && lnk.aw_idunq;
      end
   end

   // Write pointers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rq_wp_r <= '0;
         wq_wp_r <= '0;
      end else begin
         if (ar_hs)
            rq_wp_r <= rq_wp_r + 1'b1;
         if (aw_hs)
            wq_wp_r <= wq_wp_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Response sequencer: whole read bursts in order, no interleave
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= uidp_pkg::UIDP_IDLE;
         rq_rp_r <= '0;
         wq_rp_r <= '0;
         beat_r <= uidp_pkg::CNT_RST;
         r_valid_r <= 1'b0;
         r_id_r <= '0;
         r_idunq_r <= 1'b0;
         r_last_r <= 1'b0;
         b_valid_r <= 1'b0;
         b_id_r <= '0;
         b_idunq_r <= 1'b0;
      end else begin
         case (state_r)
            uidp_pkg::UIDP_IDLE: begin
               if (!rq_empty) begin
                  // One burst completes before the next ID starts
                  state_r <= uidp_pkg::UIDP_RDAT;
                  r_valid_r <= 1'b1;
                  r_id_r <= rq_id[rq_rp_r[PW-1:0]];
                  r_idunq_r <= rq_unq[rq_rp_r[PW-1:0]];
                  r_last_r <= RBEATS == 1;
                  beat_r <= 8'h01;
               end else if (!wq_empty) begin
                  state_r <= uidp_pkg::UIDP_WRSP;
                  b_valid_r <= 1'b1;
                  b_id_r <= wq_id[wq_rp_r[PW-1:0]];
                  b_idunq_r <= wq_unq[wq_rp_r[PW-1:0]];
               end
            end
            uidp_pkg::UIDP_RDAT: begin
               if (r_hs) begin
                  if (r_last_r) begin
                     // Outstanding ends with the accepted last beat
                     rq_rp_r <= rq_rp_r + 1'b1;
                     r_valid_r <= 1'b0;
                     r_last_r <= 1'b0;
                     r_idunq_r <= 1'b0;
                     state_r <= uidp_pkg::UIDP_IDLE;
                  end else begin
                     beat_r <= beat_r + 8'h01;
                     r_last_r <= beat_r + 8'h01 == 8'(RBEATS);
                  end
               end
            end
            uidp_pkg::UIDP_WRSP: begin
               if (b_hs) begin
                  wq_rp_r <= wq_rp_r + 1'b1;
                  b_valid_r <= 1'b0;
                  b_idunq_r <= 1'b0;
                  state_r <= uidp_pkg::UIDP_IDLE;
               end
            end
            default: state_r <= uidp_pkg::UIDP_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Partition sampling, only with address valid; DVM reads and reads accepted with a write skipped
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         part_vld_r <= 1'b0;
         part_id_r <= uidp_pkg::PART_ID_RST;
         part_mg_r <= uidp_pkg::PART_MG_RST;
         part_ns_r <= 1'b0;
         part_wr_r <= 1'b0;
      end else begin
         part_vld_r <= 1'b0;
         if (PART_SUPPORT && aw_hs) begin
            part_vld_r <= 1'b1;
            part_wr_r <= 1'b1;
            part_ns_r <= lnk.aw_part[uidp_pkg::PART_NS_POS];
            part_id_r <= lnk.aw_part[uidp_pkg::PART_ID_MSB:
                                     uidp_pkg::PART_ID_LSB];
            part_mg_r <= lnk.aw_part[uidp_pkg::PART_MG_POS];
         end else if (PART_SUPPORT && ar_hs && !lnk.ar_dvm) begin
            part_vld_r <= 1'b1;
            part_wr_r <= 1'b0;
            part_ns_r <= lnk.ar_part[uidp_pkg::PART_NS_POS];
            part_id_r <= lnk.ar_part[uidp_pkg::PART_ID_MSB:
                                     uidp_pkg::PART_ID_LSB];
            part_mg_r <= lnk.ar_part[uidp_pkg::PART_MG_POS];
         end
      end
   end

   // Link outputs; flags forced low when unique IDs unsupported
   assign lnk.ar_ready = ar_ready_r;
   assign lnk.aw_ready = aw_ready_r;
   assign lnk.r_valid = r_valid_r;
   assign lnk.r_id = r_id_r;
   assign lnk.r_idunq = r_idunq_r && UNIQUE_ID_SUPPORT;
   assign lnk.r_last = r_last_r;
   assign lnk.b_valid = b_valid_r;
   assign lnk.b_id = b_id_r;
   assign lnk.b_idunq = b_idunq_r && UNIQUE_ID_SUPPORT;
   assign lnk.b_comp = b_valid_r;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench joining both ends of the sideband link
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int RB = 3;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic rd_req = 1'b0, rd_dvm = 1'b0, wr_req = 1'b0;
   logic [3:0] rd_id = 4'h0, wr_id = 4'h0;
   logic [2:0] rd_prot = 3'h0, wr_prot = 3'h0;
   logic part_own = 1'b0, part_ns = 1'b0, part_mg = 1'b0;
   logic [8:0] part_id = 9'h000;
   logic part_vld_r, part_mg_r, part_ns_r, part_wr_r;
   logic [8:0] part_id_r;
   logic rd_busy_r, wr_busy_r, rd_done_r, wr_done_r;
   logic [3:0] st_r = 4'h0;
   logic [10:0] arp_r = 11'h000, awp_r = 11'h000;
   logic ardvm_r = 1'b0;
   logic [15:0] rq[$], wq[$], e;
   logic [3:0] rdq[$], wdq[$];
   int bad_count = 0, tests_run = 0, rbeats = 0;
   logic [31:0] seed = 32'd13515;

   // Clock
   always #20 mclk = ~mclk;

   uidp_link_if #(.ID_W(4)) lnk();
   uidp_mst #(.ID_W(4)) i_uidp_mst(.mclk(mclk), .rst(rst), .lnk(lnk),
      .rd_req(rd_req), .rd_id(rd_id), .rd_dvm(rd_dvm), .rd_prot(rd_prot),
      .wr_req(wr_req), .wr_id(wr_id), .wr_prot(wr_prot),
      .part_own(part_own), .part_ns(part_ns), .part_id(part_id),
      .part_mg(part_mg), .rd_busy_r(rd_busy_r), .wr_busy_r(wr_busy_r),
      .rd_done_r(rd_done_r), .wr_done_r(wr_done_r));
   uidp_sub #(.ID_W(4), .DEPTH(2), .RBEATS(RB)) i_uidp_sub(.mclk(mclk),
      .rst(rst), .lnk(lnk), .part_vld_r(part_vld_r), .part_id_r(part_id_r),
      .part_mg_r(part_mg_r), .part_ns_r(part_ns_r), .part_wr_r(part_wr_r));
   uidp_chk #(.ID_W(4)) i_uidp_chk(.mclk(mclk), .rst(rst),
      .ar_valid(lnk.ar_valid), .ar_ready(lnk.ar_ready), .ar_id(lnk.ar_id),
      .ar_idunq(lnk.ar_idunq), .r_valid(lnk.r_valid), .r_ready(lnk.r_ready),
      .r_id(lnk.r_id), .r_idunq(lnk.r_idunq), .r_last(lnk.r_last),
      .aw_valid(lnk.aw_valid), .aw_ready(lnk.aw_ready), .aw_id(lnk.aw_id),
      .aw_idunq(lnk.aw_idunq), .b_valid(lnk.b_valid), .b_ready(lnk.b_ready),
      .b_id(lnk.b_id), .b_idunq(lnk.b_idunq), .b_comp(lnk.b_comp));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected partition word: own fields or system defaults
   function automatic logic [10:0] expart(input logic [2:0] prot);
      if (part_own) return {part_mg, part_id, part_ns};
      return {uidp_pkg::PART_MG_RST, uidp_pkg::PART_ID_RST,
         prot[uidp_pkg::PROT_NS_POS]};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Read request held until the master raises its address valid
   task automatic issue_rd(input logic [3:0] id, input logic dvm,
      input logic [2:0] prot);
      int n;
      n = 0;
      rd_req = 1'b1;
      rd_id = id;
      rd_dvm = dvm;
      rd_prot = prot;
      rq.push_back({dvm, id, expart(prot)});
      rdq.push_back(id);
      do begin
         @(negedge mclk);
         if (lnk.ar_valid) rd_req = 1'b0;
         n++;
      end while (!(lnk.ar_valid && lnk.ar_ready) && n < 400);
      if (!(lnk.ar_valid && lnk.ar_ready)) bad_count++;
      @(negedge mclk);
   endtask

   task automatic issue_wr(input logic [3:0] id, input logic [2:0] prot);
      int n;
      n = 0;
      wr_req = 1'b1;
      wr_id = id;
      wr_prot = prot;
      wq.push_back({1'b0, id, expart(prot)});
      wdq.push_back(id);
      do begin
         @(negedge mclk);
         if (lnk.aw_valid) wr_req = 1'b0;
         n++;
      end while (!(lnk.aw_valid && lnk.aw_ready) && n < 400);
      if (!(lnk.aw_valid && lnk.aw_ready)) bad_count++;
      @(negedge mclk);
   endtask

   // Random mix of reads, DVM reads and writes, often on shared IDs
   task automatic run(input int cnt);
      logic [31:0] r;
      for (int i = 0; i < cnt; i++) begin
         r = rnd();
         {part_mg, part_id, part_ns, part_own} = r[11:0];
         fork
            if (r[12] || !r[15])
               issue_rd(r[13] ? r[19:16] : {2'b00, r[17:16]}, r[20] & r[21],
                  r[24:22]);
            if (r[15])
               issue_wr(r[14] ? r[28:25] : {2'b00, r[26:25]}, r[31:29]);
         join
      end
   endtask

   task automatic drain();
      int n;
      n = 0;
      while ((rdq.size() != 0 || wdq.size() != 0) && n < 2000) begin
         @(negedge mclk);
         n++;
      end
      if (rdq.size() != 0 || wdq.size() != 0) bad_count++;
   endtask

   // ----------------------------------------------------------------
   // Output monitor
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      if (!rst) begin
         if (lnk.ar_valid) begin
            arp_r <= lnk.ar_part;
            ardvm_r <= lnk.ar_dvm;
         end
         if (lnk.aw_valid) awp_r <= lnk.aw_part;
         if (lnk.ar_valid && lnk.ar_ready) begin
            e = rq.size() ? rq.pop_front() : 'x;
            chk({lnk.ar_dvm, lnk.ar_id}, e[15:11]);
            if (!e[15]) chk(lnk.ar_part, e[10:0]);
         end
         if (lnk.aw_valid && lnk.aw_ready) begin
            e = wq.size() ? wq.pop_front() : 'x;
            chk({lnk.aw_id, lnk.aw_part}, e);
         end
         if (lnk.r_valid && lnk.r_ready) begin
            rbeats++;
            if (lnk.r_last) begin
               chk(16'(rbeats), 16'(RB));
               chk(lnk.r_id, rdq.size() ? rdq.pop_front() : 'x);
               rbeats = 0;
            end
         end
         if (lnk.b_valid && lnk.b_ready) begin
            chk(lnk.b_comp, 1'b1);
            chk(lnk.b_id, wdq.size() ? wdq.pop_front() : 'x);
         end
         if (part_vld_r && !(ardvm_r && !part_wr_r))
            chk({part_mg_r, part_id_r, part_ns_r}, part_wr_r ? awp_r : arp_r);
         // Status outputs trail the link by one cycle
         chk({rd_busy_r, wr_busy_r, rd_done_r, wr_done_r}, st_r);
         st_r <= {lnk.ar_valid, lnk.aw_valid,
            lnk.r_valid && lnk.r_ready && lnk.r_last,
            lnk.b_valid && lnk.b_ready && lnk.b_comp};
      end else
         st_r <= 4'h0;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      run(70);
      drain();
      // Second reset once the first run has drained, then more traffic
      rst = 1'b1;
      rbeats = 0;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      run(30);
      drain();
      end_of_test();
   end

   // Watchdog
   initial begin
      #(40 * 40000);
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire

// ==== testbench/uidp_assertions.sv ====
// Concurrent checks on the link between master and subordinate
`timescale 1ns/1ns
`default_nettype none
module uidp_chk #(
   parameter int ID_W = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Read address and data
   input wire logic ar_valid,
   input wire logic ar_ready,
   input wire logic [ID_W-1:0] ar_id,
   input wire logic ar_idunq,
   input wire logic r_valid,
   input wire logic r_ready,
   input wire logic [ID_W-1:0] r_id,
   input wire logic r_idunq,
   input wire logic r_last,
   // Write address and response
   input wire logic aw_valid,
   input wire logic aw_ready,
   input wire logic [ID_W-1:0] aw_id,
   input wire logic aw_idunq,
   input wire logic b_valid,
   input wire logic b_ready,
   input wire logic [ID_W-1:0] b_id,
   input wire logic b_idunq,
   input wire logic b_comp
);
   localparam int NID = 2 ** ID_W;
   logic rhs, rdn, whs, wdn;
   logic [7:0] rcnt_r [NID];
   logic [7:0] wcnt_r [NID];
   logic [NID-1:0] rflg_r, wflg_r;
   logic mid_r;
   logic [ID_W-1:0] mid_id_r;

   assign rhs = ar_valid && ar_ready;
   assign rdn = r_valid && r_ready && r_last;
   assign whs = aw_valid && aw_ready;
   assign wdn = b_valid && b_ready && b_comp;

   // Outstanding transactions per ID
   always_ff @(posedge mclk or posedge rst) begin
      for (int i = 0; i < NID; i++) begin
         if (rst) begin
            rcnt_r[i] <= 8'h00;
            wcnt_r[i] <= 8'h00;
         end else begin
            rcnt_r[i] <= rcnt_r[i] + 8'(rhs && ar_id == ID_W'(i))
               - 8'(rdn && r_id == ID_W'(i));
            wcnt_r[i] <= wcnt_r[i] + 8'(whs && aw_id == ID_W'(i))
               - 8'(wdn && b_id == ID_W'(i));
         end
      end
   end

   // Unique flag of the latest accepted request per ID
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rflg_r <= '0;
         wflg_r <= '0;
      end else begin
         if (rhs) rflg_r[ar_id] <= ar_idunq;
         if (whs) wflg_r[aw_id] <= aw_idunq;
      end
   end

   // Read burst in progress
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mid_r <= 1'b0;
         mid_id_r <= '0;
      end else if (r_valid && r_ready) begin
         mid_r <= !r_last;
         mid_id_r <= r_id;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   rd_unq_free_a: assert property (rhs && ar_idunq |-> rcnt_r[ar_id] == 8'h00)
      else $error("read unique flag with same ID outstanding");
   rd_unq_reuse_a: assert property (rhs |-> !(rflg_r[ar_id] && rcnt_r[ar_id] != 8'h00))
      else $error("read reuses an outstanding unique ID");
   rd_flag_low_a: assert property (r_valid && !rflg_r[r_id] |-> !r_idunq)
      else $error("read data unique flag high for plain request");
   rd_flag_high_a: assert property (r_valid && rflg_r[r_id] |-> r_idunq)
      else $error("read data unique flag low for unique request");
   wr_unq_free_a: assert property (whs && aw_idunq |-> wcnt_r[aw_id] == 8'h00)
      else $error("write unique flag with same ID outstanding");
   wr_flag_echo_a: assert property (b_valid |-> b_idunq == wflg_r[b_id])
      else $error("write response unique flag differs from request");
   rd_outstanding_a: assert property (r_valid |-> rcnt_r[r_id] != 8'h00)
      else $error("read data without outstanding read");
   wr_comp_set_a: assert property (b_valid |-> b_comp && wcnt_r[b_id] != 8'h00)
      else $error("write response without completion or request");
   no_interleave_a: assert property (r_valid && mid_r |-> r_id == mid_id_r)
      else $error("read data interleaved between IDs");
   ar_hold_a: assert property (ar_valid && !ar_ready |=> ar_valid && $stable(ar_id) && $stable(ar_idunq))
      else $error("read request changed before acceptance");

   // Main scenarios reached
   cover property (rhs && ar_idunq);
   cover property (rdn && !r_idunq);
   cover property (r_valid && mid_r);
   cover property (ar_valid && !ar_ready);
endmodule
`default_nettype wire
